// ---- hdl/tc8_defines.svh ----
`ifndef TC8_DEFINES_SVH
`define TC8_DEFINES_SVH

// ************************************************************
// register map (byte addresses on the plain register port)
// ************************************************************
`define TC8_AW          3
`define TC8_ADDR_CTRL_A 3'h0
`define TC8_ADDR_CTRL_B 3'h1
`define TC8_ADDR_COUNT  3'h2
`define TC8_ADDR_CMP_A  3'h3
`define TC8_ADDR_CMP_B  3'h4
`define TC8_ADDR_MASK   3'h5
`define TC8_ADDR_FLAG   3'h6

// ************************************************************
// field positions
// ************************************************************
`define TC8_CA_WGM      1:0
`define TC8_CA_COM_B    5:4
`define TC8_CA_COM_A    7:6
`define TC8_CB_CS       2:0
`define TC8_CB_WGM2     3
`define TC8_CB_FORCE_B  6
`define TC8_CB_FORCE_A  7
`define TC8_FLG         2:0
`define TC8_FLG_OVF     0
`define TC8_FLG_CMP_A   1
`define TC8_FLG_CMP_B   2

// ************************************************************
// values
// ************************************************************
`define TC8_RST_BYTE    8'h00
`define TC8_BOTTOM      8'h00
`define TC8_MAX         8'hff
`define TC8_ONE         8'h01
`define TC8_RST_FLAGS   3'h0
`define TC8_RST_COM     2'h0
`define TC8_COM_OFF     2'h0
`define TC8_COM_TOGGLE  2'h1
`define TC8_COM_CLEAR   2'h2
`define TC8_COM_SET     2'h3

// ************************************************************
// prescaler taps: tick when all masked bits are ones
// ************************************************************
`define TC8_PS_W        10
`define TC8_PS_RST      10'h000
`define TC8_PS_ONE      10'h001
`define TC8_PS_DIV8     10'h007
`define TC8_PS_DIV64    10'h03f
`define TC8_PS_DIV256   10'h0ff
`define TC8_PS_DIV1024  10'h3ff

`endif

// ---- hdl/tc8_pkg.sv ----
package tc8_pkg;

  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tc8_clk_sel_t;

  typedef enum logic [2:0] {
    WM_NORMAL    = 3'b000,
    WM_PC_MAX    = 3'b001,
    WM_CTC       = 3'b010,
    WM_FAST_MAX  = 3'b011,
    WM_RSV4      = 3'b100,
    WM_PC_OCRA   = 3'b101,
    WM_RSV6      = 3'b110,
    WM_FAST_OCRA = 3'b111
  } tc8_mode_t;

endpackage : tc8_pkg

// ---- hdl/tc8_tick_if.sv ----
`timescale 1ns/1ps
interface tc8_tick_if;
  tc8_pkg::tc8_clk_sel_t clock_source_select;
  logic                  external_count_input;
  logic                  timer_tick;

  modport core (output clock_source_select, output external_count_input, input timer_tick);
  modport sel  (input clock_source_select, input external_count_input, output timer_tick);
endinterface : tc8_tick_if

// ---- hdl/tc8_tick_sel.sv ----
`timescale 1ns/1ps
`include "tc8_defines.svh"

module tc8_tick_sel (
  input  wire logic clock,
  input  wire logic ce,
  input  wire logic rst,
  tc8_tick_if.sel   tk
);
  logic [`TC8_PS_W-1:0] presc_reg;
  logic                 ext_s1_reg;
  logic                 ext_s2_reg;
  logic                 ext_s3_reg;
  wire                  ext_rise;
  wire                  ext_fall;
  wire                  ps_8;
  wire                  ps_64;
  wire                  ps_256;
  wire                  ps_1024;
  logic                 tick_sel;

  // ************************************************************
  // prescaler and pin synchroniser
  // ************************************************************
  // prescaler is free running; a new selection is not phase aligned
  always_ff @(posedge clock) begin
    if (rst) begin
      presc_reg  <= `TC8_PS_RST;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else if (ce) begin
      presc_reg  <= presc_reg + `TC8_PS_ONE;
      ext_s1_reg <= tk.external_count_input;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_rise = ext_s2_reg & ~ext_s3_reg;
  assign ext_fall = ~ext_s2_reg & ext_s3_reg;
  assign ps_8     = (presc_reg & `TC8_PS_DIV8) == `TC8_PS_DIV8;
  assign ps_64    = (presc_reg & `TC8_PS_DIV64) == `TC8_PS_DIV64;
  assign ps_256   = (presc_reg & `TC8_PS_DIV256) == `TC8_PS_DIV256;
  assign ps_1024  = (presc_reg & `TC8_PS_DIV1024) == `TC8_PS_DIV1024;

  // ************************************************************
  // source and edge selection
  // ************************************************************
  always_comb begin
    unique case (tk.clock_source_select)
      tc8_pkg::CS_STOP:     tick_sel = 1'b0; // R04
      tc8_pkg::CS_DIV1:     tick_sel = 1'b1;
      tc8_pkg::CS_DIV8:     tick_sel = ps_8;
      tc8_pkg::CS_DIV64:    tick_sel = ps_64;
      tc8_pkg::CS_DIV256:   tick_sel = ps_256;
      tc8_pkg::CS_DIV1024:  tick_sel = ps_1024;
      tc8_pkg::CS_EXT_FALL: tick_sel = ext_fall; // R03
      tc8_pkg::CS_EXT_RISE: tick_sel = ext_rise; // R03
    endcase
  end

  assign tk.timer_tick = ce & tick_sel;
endmodule : tc8_tick_sel

// ---- hdl/tc8_core.sv ----
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tc8_defines.svh"

// Notes on behaviour
// R01: count and both compare values are 8-bit
// R02: each request has flag and mask bit
// R03: tick from prescaler or external pin edge
// R04: no source selected means no counting
// R05: control b field picks tick source
// R06: compare equality sets that unit's flag
// R07: compare result drives pwm or frequency pin
// R08: floor is count value 0x00
// R09: maximum is count value 0xFF
// R10: top is 0xFF or compare a
// R11: counter counts up and down
// R12: compare values pass through a buffer
// R13: overflow, compare a, compare b sources
// R14: clear on compare match mode
// R15: phase correct pwm with variable period
// R16: cpu count write beats clear or count
// R17: each tick steps by one or clears
// R18: match sets flag one tick later
// R19: flag cleared by service or writing one
// R20: reset zeroes count, compares and flags
module tc8_core (
  input  wire logic                clock,
  input  wire logic                ce,
  input  wire logic                rst,
  input  wire logic [`TC8_AW-1:0]  addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [7:0]          rdata,
  input  wire logic                external_count_input,
  input  wire logic                ack_overflow,
  input  wire logic                ack_compare_a,
  input  wire logic                ack_compare_b,
  output logic                     irq_overflow,
  output logic                     irq_compare_a,
  output logic                     irq_compare_b,
  output logic                     compare_output_a,
  output logic                     compare_output_a_en,
  output logic                     compare_output_b,
  output logic                     compare_output_b_en
);
  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]            ctrl_a_reg;
  tc8_pkg::tc8_clk_sel_t cs_reg;
  logic                  wgm2_reg;
  logic [7:0]            cnt_reg; // R01
  logic [7:0]            cnt_next;
  logic                  dir_up_reg;
  logic                  dir_up_next;
  logic                  blk_reg;
  logic [2:0]            mask_reg;
  logic [2:0]            flag_reg;
  logic [2:0]            flag_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            ocr_buf_reg [2];
  logic [7:0]            ocr_act_reg [2];
  logic                  oc_reg      [2];

  tc8_tick_if tk ();

  tc8_tick_sel u_tick (
    .clock (clock),
    .ce    (ce),
    .rst   (rst),
    .tk    (tk.sel)
  );

  // ************************************************************
  // decode
  // ************************************************************
  tc8_pkg::tc8_mode_t mode;
  wire       tick       = tk.timer_tick;
  wire       wr_ctrl_a  = wr_en & (addr == `TC8_ADDR_CTRL_A);
  wire       wr_ctrl_b  = wr_en & (addr == `TC8_ADDR_CTRL_B);
  wire       cnt_wr     = wr_en & (addr == `TC8_ADDR_COUNT);
  wire       wr_mask    = wr_en & (addr == `TC8_ADDR_MASK);
  wire       wr_flag    = wr_en & (addr == `TC8_ADDR_FLAG);
  wire [1:0] wr_ocr     = {wr_en & (addr == `TC8_ADDR_CMP_B), wr_en & (addr == `TC8_ADDR_CMP_A)};
  wire [1:0] force_ev   = {wr_ctrl_b & wdata[`TC8_CB_FORCE_B], wr_ctrl_b & wdata[`TC8_CB_FORCE_A]};
  wire [1:0] com_a      = ctrl_a_reg[`TC8_CA_COM_A];
  wire [1:0] com_b      = ctrl_a_reg[`TC8_CA_COM_B];

  assign mode = tc8_pkg::tc8_mode_t'({wgm2_reg, ctrl_a_reg[`TC8_CA_WGM]});
  assign tk.clock_source_select  = cs_reg; // R05
  assign tk.external_count_input = external_count_input;

  wire pc_mode   = (mode == tc8_pkg::WM_PC_MAX) | (mode == tc8_pkg::WM_PC_OCRA); // R15
  wire fast_mode = (mode == tc8_pkg::WM_FAST_MAX) | (mode == tc8_pkg::WM_FAST_OCRA);
  wire pwm_mode  = pc_mode | fast_mode;
  wire ctc_mode  = (mode == tc8_pkg::WM_CTC);
  wire top_ocra  = (mode == tc8_pkg::WM_PC_OCRA) | (mode == tc8_pkg::WM_FAST_OCRA);

  wire [7:0] top_val   = top_ocra ? ocr_act_reg[0] : `TC8_MAX; // R10
  wire       at_bottom = (cnt_reg == `TC8_BOTTOM); // R08
  wire       at_max    = (cnt_reg == `TC8_MAX); // R09
  wire       at_top    = (cnt_reg == top_val);
  wire       ctc_hit   = ctc_mode & (cnt_reg == ocr_act_reg[0]);
  // ctc and fast modes wrap to bottom instead of stepping
  wire       clr_wrap  = ctc_hit | (fast_mode & at_top); // R14
  wire       ovf_cond  = pc_mode ? (at_bottom & ~dir_up_reg) : fast_mode ? at_top : at_max;

  // ************************************************************
  // counter unit
  // ************************************************************
  always_comb begin
    cnt_next    = cnt_reg;
    dir_up_next = pc_mode ? dir_up_reg : 1'b1;
    if (cnt_wr) begin
      cnt_next = wdata; // R16
    end else if (tick) begin // R17
      if (pc_mode) begin // R11
        if (dir_up_reg) begin
          if (at_top) begin
            dir_up_next = 1'b0;
            cnt_next    = cnt_reg - `TC8_ONE;
          end else begin
            cnt_next = cnt_reg + `TC8_ONE;
          end
        end else begin
          if (at_bottom) begin
            dir_up_next = 1'b1;
            cnt_next    = cnt_reg + `TC8_ONE;
          end else begin
            cnt_next = cnt_reg - `TC8_ONE;
          end
        end
      end else if (clr_wrap) begin
        cnt_next = `TC8_BOTTOM; // R14
      end else begin
        cnt_next = cnt_reg + `TC8_ONE;
      end
    end
  end

  // ************************************************************
  // compare units
  // ************************************************************
  logic [1:0] match;
  logic [1:0] oc_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
      wire [1:0] com    = (gi == 0) ? com_a : com_b;
      wire       tog_ok = (gi == 0) & top_ocra;
      wire [7:0] buf_next;
      wire [7:0] act_next;
      wire       hit_ev;
      logic      oc_next;

      // a count write masks the match for one tick
      assign match[gi] = (cnt_reg == ocr_act_reg[gi]) & ~blk_reg; // R06
      assign hit_ev    = tick & match[gi];
      assign buf_next  = wr_ocr[gi] ? wdata : ocr_buf_reg[gi];
      // pwm modes load the comparator only at top to avoid odd pulses
      assign act_next  = !pwm_mode ? buf_next :
                         (tick & at_top) ? ocr_buf_reg[gi] : ocr_act_reg[gi]; // R12

      always_comb begin // R07
        oc_next = oc_reg[gi];
        if (!pwm_mode) begin
          if (hit_ev | force_ev[gi]) begin
            unique case (com)
              `TC8_COM_OFF:    oc_next = oc_reg[gi];
              `TC8_COM_TOGGLE: oc_next = ~oc_reg[gi];
              `TC8_COM_CLEAR:  oc_next = 1'b0;
              `TC8_COM_SET:    oc_next = 1'b1;
            endcase
          end
        end else if (com == `TC8_COM_TOGGLE) begin
          if (hit_ev & tog_ok) begin
            oc_next = ~oc_reg[gi];
          end
        end else if (com != `TC8_COM_OFF) begin
          if (hit_ev) begin
            oc_next = (com == `TC8_COM_SET) ^ (pc_mode & ~dir_up_reg);
          end else if (fast_mode & tick & at_top) begin
            oc_next = (com == `TC8_COM_CLEAR);
          end
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          ocr_buf_reg[gi] <= `TC8_RST_BYTE; // R20
          ocr_act_reg[gi] <= `TC8_RST_BYTE;
          oc_reg[gi]      <= 1'b0;
        end else if (ce) begin
          ocr_buf_reg[gi] <= buf_next;
          ocr_act_reg[gi] <= act_next;
          oc_reg[gi]      <= oc_next;
        end
      end

      assign oc_out[gi] = oc_reg[gi];
    end
  endgenerate

  // ************************************************************
  // flags
  // ************************************************************
  wire [2:0] flag_set = {tick & match[1], tick & match[0], tick & ovf_cond}; // R13
  wire [2:0] flag_clr = (wr_flag ? wdata[`TC8_FLG] : `TC8_RST_FLAGS) |
                        {ack_compare_b, ack_compare_a, ack_overflow}; // R19
  // set beats clear so an event in the clearing cycle survives
  assign flag_next = (flag_reg & ~flag_clr) | flag_set; // R18

  // ************************************************************
  // read mux
  // ************************************************************
  wire [7:0] ctrl_b_view = {4'h0, wgm2_reg, cs_reg};
  wire [7:0] rd_mux =
      (addr == `TC8_ADDR_CTRL_A) ? ctrl_a_reg :
      (addr == `TC8_ADDR_CTRL_B) ? ctrl_b_view :
      (addr == `TC8_ADDR_COUNT)  ? cnt_reg :
      (addr == `TC8_ADDR_CMP_A)  ? ocr_buf_reg[0] :
      (addr == `TC8_ADDR_CMP_B)  ? ocr_buf_reg[1] :
      (addr == `TC8_ADDR_MASK)   ? {5'h00, mask_reg} :
      (addr == `TC8_ADDR_FLAG)   ? {5'h00, flag_reg} : `TC8_RST_BYTE;

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_a_reg <= `TC8_RST_BYTE;
      cs_reg     <= tc8_pkg::CS_STOP;
      wgm2_reg   <= 1'b0;
      cnt_reg    <= `TC8_RST_BYTE; // R20
      dir_up_reg <= 1'b1;
      blk_reg    <= 1'b0;
      mask_reg   <= `TC8_RST_FLAGS;
      flag_reg   <= `TC8_RST_FLAGS;
      rdata_reg  <= `TC8_RST_BYTE;
    end else if (ce) begin
      if (wr_ctrl_a) begin
        ctrl_a_reg <= wdata;
      end
      if (wr_ctrl_b) begin
        cs_reg   <= tc8_pkg::tc8_clk_sel_t'(wdata[`TC8_CB_CS]); // R05
        wgm2_reg <= wdata[`TC8_CB_WGM2];
      end
      if (wr_mask) begin
        mask_reg <= wdata[`TC8_FLG];
      end
      cnt_reg    <= cnt_next;
      dir_up_reg <= dir_up_next;
      blk_reg    <= cnt_wr | (blk_reg & ~tick);
      flag_reg   <= flag_next;
      rdata_reg  <= rd_en ? rd_mux : `TC8_RST_BYTE;
    end
  end

  assign rdata               = rdata_reg;
  assign irq_overflow        = flag_reg[`TC8_FLG_OVF] & mask_reg[`TC8_FLG_OVF]; // R02
  assign irq_compare_a       = flag_reg[`TC8_FLG_CMP_A] & mask_reg[`TC8_FLG_CMP_A]; // R02
  assign irq_compare_b       = flag_reg[`TC8_FLG_CMP_B] & mask_reg[`TC8_FLG_CMP_B]; // R02
  assign compare_output_a    = oc_out[0];
  assign compare_output_b    = oc_out[1];
  assign compare_output_a_en = (com_a != `TC8_COM_OFF);
  assign compare_output_b_en = (com_b != `TC8_COM_OFF);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_stop_holds: assert property ( // R04
    (ce && cs_reg == tc8_pkg::CS_STOP && !cnt_wr) |=> $stable(cnt_reg))
    else $error("count moved with no tick source");
  chk_write_wins: assert property ( // R16
    (ce && cnt_wr) |=> (cnt_reg == $past(wdata)))
    else $error("count write did not take priority");
  chk_flag_a_set: assert property ( // R18
    (ce && tick && match[0]) |=> flag_reg[1] ##0 $past(cnt_reg) == ocr_act_reg[0])
    else $error("compare a match did not set its flag");
  chk_flag_b_set: assert property ( // R06
    (ce && tick && cnt_reg == ocr_act_reg[1] && !blk_reg) |=> flag_reg[2])
    else $error("compare b match did not set its flag");
  chk_flag_w1c: assert property ( // R19
    (ce && flag_reg[1] && wr_flag && wdata[1] && !(tick && match[0])) |=> !flag_reg[1])
    else $error("compare a flag not cleared by write of one");
  chk_normal_step: assert property ( // R17
    (ce && tick && !cnt_wr && mode == tc8_pkg::WM_NORMAL)
      |=> (cnt_reg == 8'($past(cnt_reg) + `TC8_ONE)))
    else $error("normal mode did not step by one");
  chk_ctc_clear: assert property ( // R14
    (ce && tick && !cnt_wr && ctc_hit) |=> (cnt_reg == `TC8_BOTTOM))
    else $error("ctc mode did not clear on match");
  chk_pc_down: assert property ( // R11
    (ce && tick && !cnt_wr && pc_mode && !dir_up_reg && !at_bottom)
      |=> (cnt_reg == 8'($past(cnt_reg) - `TC8_ONE)))
    else $error("phase correct mode did not count down");
  chk_buf_hold: assert property ( // R12
    (ce && pwm_mode && wr_ocr[0] && !tick) |=> $stable(ocr_act_reg[0]))
    else $error("buffered compare a changed off top");
  chk_ovf_max: assert property ( // R09
    (ce && tick && mode == tc8_pkg::WM_NORMAL && at_max) |=> flag_reg[`TC8_FLG_OVF])
    else $error("overflow flag not set at maximum");
  chk_irq_gate: assert property ( // R02
    (flag_reg[2] && !mask_reg[2]) |-> !irq_compare_b)
    else $error("masked compare b request escaped");

  cov_ctc_wrap:  cover property (ce && tick && ctc_hit ##1 cnt_reg == `TC8_BOTTOM);
  cov_pc_turn:   cover property (pc_mode && dir_up_reg ##1 !dir_up_reg);
  cov_fast_pin:  cover property (fast_mode && compare_output_a_en ##1 $changed(oc_reg[0]));
  cov_ovf_irq:   cover property (irq_overflow);
endmodule : tc8_core

// ---- verification/timer_counter_8bit_core_bench.sv ----
`timescale 1ns/1ps
`include "tc8_defines.svh"

module timer_counter_8bit_core_bench;
  logic               clock = 1'b0;
  logic               rst   = 1'b1;
  logic               ce    = 1'b1;
  logic [`TC8_AW-1:0] addr  = '0;
  logic [7:0]         wdata = 8'h00;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic               ext_in = 1'b0;
  logic [2:0]         acks  = 3'h0;
  logic [7:0]         rdata;
  logic [2:0]         irqs;
  logic               oc_a;
  logic               oc_a_en;
  int                 miscompares = 0;
  int                 tests_run   = 0;
  int                 cycles      = 0;
  logic [7:0]         v;
  logic [7:0]         x;
  logic               prev;
  int                 n;

  tc8_core dut (
    .clock                (clock),
    .ce                   (ce),
    .rst                  (rst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rdata                (rdata),
    .external_count_input (ext_in),
    .ack_overflow         (acks[0]),
    .ack_compare_a        (acks[1]),
    .ack_compare_b        (acks[2]),
    .irq_overflow         (irqs[0]),
    .irq_compare_a        (irqs[1]),
    .irq_compare_b        (irqs[2]),
    .compare_output_a     (oc_a),
    .compare_output_a_en  (oc_a_en),
    .compare_output_b     (),
    .compare_output_b_en  ()
  );

  always #12.5 clock = ~clock;

  // ************************************************************
  // bus and pin tasks
  // ************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // one full pulse per tick; slow enough for the pin synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clock);
      ext_in <= 1'b1;
      repeat (6) @(posedge clock);
      ext_in <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask : pulses

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : chk1

  function automatic logic [7:0] ctc_after(input logic [7:0] top, input int k);
    return 8'((k) % (int'(top) + 1));
  endfunction : ctc_after

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hecab7d9f));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk8("reset value", 8'h00, v);
    end
    $display("test reset done");

    for (int i = 0; i < 6; i++) begin
      x = 8'($urandom);
      wr(`TC8_ADDR_COUNT, x);
      wr(`TC8_ADDR_CMP_A, ~x);
      wr(`TC8_ADDR_CMP_B, x ^ 8'h5a);
      wr(3'h7, x);
      rd(`TC8_ADDR_COUNT, v);
      chk8("count value", x, v);
      rd(`TC8_ADDR_CMP_A, v);
      chk8("compare a", ~x, v);
      rd(`TC8_ADDR_CMP_B, v);
      chk8("compare b", x ^ 8'h5a, v);
      rd(3'h7, v);
      chk8("unmapped", 8'h00, v);
    end
    $display("test registers done");

    // every internal source overflows from 0xff within 1024 cycles
    for (int cs = 0; cs < 6; cs++) begin
      wr(`TC8_ADDR_CTRL_B, 8'h00);
      wr(`TC8_ADDR_COUNT, 8'hff);
      wr(`TC8_ADDR_FLAG, 8'h07);
      wr(`TC8_ADDR_MASK, 8'h01);
      wr(`TC8_ADDR_CTRL_B, 8'(cs));
      repeat (1100) @(posedge clock);
      wr(`TC8_ADDR_CTRL_B, 8'h00);
      rd(`TC8_ADDR_FLAG, v);
      chk1("overflow flag", cs != 0, v[0]);
      chk1("overflow irq", cs != 0, irqs[0]);
      wr(`TC8_ADDR_FLAG, 8'h01);
      rd(`TC8_ADDR_FLAG, v);
      chk1("flag write one", 1'b0, v[0]);
    end
    wr(`TC8_ADDR_COUNT, 8'h80);
    repeat (200) @(posedge clock);
    rd(`TC8_ADDR_COUNT, v);
    chk8("stopped count", 8'h80, v);
    // clock enable low: the write below must be lost
    ce <= 1'b0;
    wr(`TC8_ADDR_COUNT, 8'h55);
    ce <= 1'b1;
    rd(`TC8_ADDR_COUNT, v);
    chk8("frozen write", 8'h80, v);
    wr(`TC8_ADDR_MASK, 8'h00);
    $display("test sources done");

    for (int cs = 6; cs < 8; cs++) begin
      x = 8'($urandom_range(8'h00, 8'hf0));
      n = $urandom_range(1, 6);
      wr(`TC8_ADDR_CTRL_A, 8'h00);
      wr(`TC8_ADDR_CTRL_B, 8'(cs));
      wr(`TC8_ADDR_COUNT, x);
      pulses(n);
      rd(`TC8_ADDR_COUNT, v);
      chk8("pin count", x + 8'(n), v);
    end
    wr(`TC8_ADDR_COUNT, 8'hff);
    wr(`TC8_ADDR_FLAG, 8'h07);
    pulses(1);
    rd(`TC8_ADDR_COUNT, v);
    chk8("wrap to floor", 8'h00, v);
    rd(`TC8_ADDR_FLAG, v);
    chk1("wrap overflow", 1'b1, v[0]);
    $display("test pin done");

    for (int u = 0; u < 2; u++) begin
      x = 8'($urandom_range(8'h00, 8'hf0));
      wr(`TC8_ADDR_CMP_A + 3'(u), x + 8'h02);
      wr(`TC8_ADDR_COUNT, x);
      wr(`TC8_ADDR_FLAG, 8'h07);
      pulses(2);
      rd(`TC8_ADDR_FLAG, v);
      chk1("flag before match tick", 1'b0, v[u+1]);
      pulses(1);
      rd(`TC8_ADDR_FLAG, v);
      chk1("flag after match tick", 1'b1, v[u+1]);
      chk1("masked irq", 1'b0, irqs[u+1]);
      wr(`TC8_ADDR_MASK, 8'(2 << u));
      #1;
      chk1("unmasked irq", 1'b1, irqs[u+1]);
      @(posedge clock);
      acks[u+1] <= 1'b1;
      @(posedge clock);
      acks[u+1] <= 1'b0;
      #1;
      chk1("irq after service", 1'b0, irqs[u+1]);
      wr(`TC8_ADDR_MASK, 8'h00);
    end
    $display("test compare done");

    x = 8'($urandom_range(2, 5));
    wr(`TC8_ADDR_CTRL_A, 8'h02);
    wr(`TC8_ADDR_CMP_A, x);
    wr(`TC8_ADDR_COUNT, 8'h00);
    wr(`TC8_ADDR_FLAG, 8'h07);
    pulses(int'(x) + 1);
    rd(`TC8_ADDR_COUNT, v);
    chk8("clear on match", ctc_after(x, int'(x) + 1), v);
    rd(`TC8_ADDR_FLAG, v);
    chk1("clear match flag", 1'b1, v[1]);
    $display("test ctc done");

    wr(`TC8_ADDR_CTRL_A, 8'h01);
    wr(`TC8_ADDR_COUNT, 8'hfd);
    pulses(2);
    rd(`TC8_ADDR_COUNT, v);
    chk8("phase correct top", 8'hff, v);
    pulses(2);
    rd(`TC8_ADDR_COUNT, v);
    chk8("phase correct down", 8'hfd, v);
    $display("test updown done");

    wr(`TC8_ADDR_CTRL_A, 8'h40);
    for (int i = 0; i < 2; i++) begin
      prev = oc_a;
      wr(`TC8_ADDR_CTRL_B, 8'h87);
      repeat (2) @(posedge clock);
      #1;
      chk1("forced toggle", ~prev, oc_a);
      chk1("output enable", 1'b1, oc_a_en);
    end
    $display("test output done");

    // fast mode, top 0xff, pin set at top; compare a write stays buffered until top
    wr(`TC8_ADDR_CTRL_A, 8'h83);
    wr(`TC8_ADDR_CMP_A, 8'h40);
    wr(`TC8_ADDR_COUNT, 8'hfe);
    wr(`TC8_ADDR_FLAG, 8'h07);
    pulses(2);
    rd(`TC8_ADDR_COUNT, v);
    chk8("fast wrap", 8'h00, v);
    rd(`TC8_ADDR_FLAG, v);
    chk1("fast overflow", 1'b1, v[0]);
    chk1("fast pin at top", 1'b1, oc_a);
    $display("test fast done");
    close_out();
  end
endmodule : timer_counter_8bit_core_bench
